// File: hdl/txc_tx_clock_loop.sv
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/100ps

module txc_tx_clock_loop
  import txc_pkg::*;
#(
  parameter int FRAME_BITS    = TXC_FRAME_BITS,
  parameter int FRAMES_PER_MF = TXC_FRAMES_PER_MF
) (
  // clock and reset
  input  wire logic                 CLOCK_I,
  input  wire logic                 RESET_I,
  // wishbone slave
  input  wire logic                 WB_CYC_I,
  input  wire logic                 WB_STB_I,
  input  wire logic                 WB_WE_I,
  input  wire logic [TXC_ADR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]           WB_SEL_I,
  input  wire logic [31:0]          WB_DAT_I,
  output logic      [31:0]          WB_DAT_O,
  output logic                      WB_ACK_O,
  // timing sources
  input  wire logic                 RECOVERED_CLK_I,
  input  wire logic                 PLL_CLK_I,
  // two-way timing pins
  input  wire logic                 TX_SERIAL_CLOCK_I,
  output logic                      TX_SERIAL_CLOCK_O,
  output logic                      TX_SERIAL_CLOCK_OE_O,
  input  wire logic                 TX_FRAME_SYNC_I,
  output logic                      TX_FRAME_SYNC_O,
  output logic                      TX_FRAME_SYNC_OE_O,
  input  wire logic                 TX_MULTIFRAME_SYNC_I,
  output logic                      TX_MULTIFRAME_SYNC_O,
  output logic                      TX_MULTIFRAME_SYNC_OE_O,
  // data
  input  wire logic                 TX_PCM_I,
  input  wire logic                 RX_LINE_I,
  output logic                      RX_PCM_O,
  output logic                      TX_LINE_POS_O,
  output logic                      TX_LINE_NEG_O
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]           tx_clock_select;
  logic [7:0]           line_interface_control;
  logic [7:0]           synchronization_mux_register;
  logic [7:0]           backplane_control;
  logic [TXC_NSYNC-1:0] sync1;
  logic [TXC_NSYNC-1:0] sync2;
  logic [TXC_NSYNC-1:0] sync3;
  logic [7:0]           bit_cnt;
  logic [4:0]           frame_cnt;
  logic                 tx_line_bit;
  logic                 serclk_level;
  logic                 fsync_out;
  logic                 mfsync_out;
  logic                 ack;
  logic [31:0]          rdata;

  wire [TXC_NSYNC-1:0] pin_async = {TX_MULTIFRAME_SYNC_I, TX_FRAME_SYNC_I, RX_LINE_I, TX_PCM_I,
                                     TX_SERIAL_CLOCK_I, PLL_CLK_I, RECOVERED_CLK_I};

  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------
  wire txc_src_t tx_timing_source_select = txc_src_t'(tx_clock_select[TXC_CSS_LSB +: 2]);
  wire txc_lb_t  framer_loopback_select  = txc_lb_t'(line_interface_control[TXC_LB_LSB +: 2]);
  wire           force_signal_loss_tx    = line_interface_control[TXC_FORCE_SIGNAL_LOSS_TX_BIT];
  wire           sync_direction_invert   = synchronization_mux_register[TXC_SYNC_DIRECTION_INVERT_BIT];
  wire           high_speed_mode         = backplane_control[TXC_HIGH_SPEED_BIT];
  wire           liu_single_rail         = backplane_control[TXC_LIU_SR_BIT];
  wire           single_rail             = line_interface_control[TXC_RAIL_BIT] & liu_single_rail;

  // ----------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------
  wire       req        = WB_CYC_I & WB_STB_I & ~ack;
  wire       wr         = req & WB_WE_I & WB_SEL_I[0];
  wire       hit_csr    = (WB_ADR_I == TXC_ADR_CLOCK_SELECT);
  wire       hit_line_interface_control   = (WB_ADR_I == TXC_ADR_LINE_IF_CTRL);
  wire       hit_smr    = (WB_ADR_I == TXC_ADR_SYNC_MUX);
  wire       hit_bpc    = (WB_ADR_I == TXC_ADR_BACKPLANE);
  wire       hit_stat   = (WB_ADR_I == TXC_ADR_STATUS);
  wire [7:0] wbyte      = WB_DAT_I[7:0];
  wire [7:0] next_line_interface_control  = {wbyte[7], wbyte[TXC_RAIL_BIT] & liu_single_rail, wbyte[5:0]};
  wire [7:0] status     = {2'b00, fsync_out, tx_line_bit, TX_FRAME_SYNC_OE_O,
                           TX_SERIAL_CLOCK_OE_O, tx_timing_source_select};
  wire [7:0] next_rbyte = hit_csr  ? tx_clock_select :
                          hit_line_interface_control ? line_interface_control :
                          hit_smr  ? synchronization_mux_register :
                          hit_bpc  ? backplane_control :
                          hit_stat ? status : 8'h00;

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      ack   <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack   <= req;
      rdata <= req ? {24'h00_0000, next_rbyte} : 32'h0000_0000;
    end
  end

  assign WB_ACK_O = ack;
  assign WB_DAT_O = rdata;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      tx_clock_select              <= TXC_RST_CLOCK_SELECT;
      line_interface_control       <= TXC_RST_LINE_IF_CTRL;
      synchronization_mux_register <= TXC_RST_SYNC_MUX;
      backplane_control            <= TXC_RST_BACKPLANE;
    end else if (wr) begin
      if (hit_csr) begin
        tx_clock_select <= wbyte;
      end
      if (hit_line_interface_control) begin
        line_interface_control <= next_line_interface_control;
      end
      if (hit_smr) begin
        synchronization_mux_register <= wbyte;
      end
      if (hit_bpc) begin
        backplane_control <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < TXC_NSYNC; g++) begin : g_sync
      always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
        end else begin
          sync1[g] <= pin_async[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // timing source selection
  // ----------------------------------------------------------------
  wire use_ext = high_speed_mode | (tx_timing_source_select == TXC_SRC_EXT);
  wire use_pll = ~use_ext & (tx_timing_source_select == TXC_SRC_PLL);
  wire use_rec = ~use_ext & ~use_pll;
  wire sel_now = use_ext ? sync2[TXC_S_EXT_CLK] :
                 use_pll ? sync2[TXC_S_PLL_CLK] : sync2[TXC_S_REC_CLK];
  wire sel_old = use_ext ? sync3[TXC_S_EXT_CLK] :
                 use_pll ? sync3[TXC_S_PLL_CLK] : sync3[TXC_S_REC_CLK];
  wire tx_tick = sel_now & ~sel_old;

  wire tx_pcm   = sync2[TXC_S_TX_PCM];
  wire rx_line  = sync2[TXC_S_RX_LINE];
  wire fs_rise  = sync2[TXC_S_FSYNC] & ~sync3[TXC_S_FSYNC];
  wire sync_out = ~high_speed_mode & sync_direction_invert;

  assign TX_SERIAL_CLOCK_OE_O    = ~use_ext;
  assign TX_SERIAL_CLOCK_O       = serclk_level;
  assign TX_FRAME_SYNC_OE_O      = sync_out;
  assign TX_MULTIFRAME_SYNC_OE_O = sync_out;
  assign TX_FRAME_SYNC_O         = fsync_out;
  assign TX_MULTIFRAME_SYNC_O    = mfsync_out;

  // ----------------------------------------------------------------
  // transmit frame timing
  // ----------------------------------------------------------------
  wire last_bit   = (bit_cnt == 8'(FRAME_BITS - 1));
  wire last_frame = (frame_cnt == 5'(FRAMES_PER_MF - 1));

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      bit_cnt      <= 8'h00;
      frame_cnt    <= 5'h00;
      serclk_level <= 1'b0;
      fsync_out    <= 1'b0;
      mfsync_out   <= 1'b0;
    end else begin
      serclk_level <= sel_now;
      if (~sync_out & fs_rise) begin
        bit_cnt   <= 8'h00;
        frame_cnt <= 5'h00;
      end else if (tx_tick) begin
        bit_cnt <= last_bit ? 8'h00 : bit_cnt + 8'h01;
        if (last_bit) begin
          frame_cnt <= last_frame ? 5'h00 : frame_cnt + 5'h01;
        end
      end
      if (tx_tick) begin
        fsync_out  <= (bit_cnt == 8'h00);
        mfsync_out <= (bit_cnt == 8'h00) & (frame_cnt == 5'h00);
      end
    end
  end

  // ----------------------------------------------------------------
  // loopback and line data paths
  // ----------------------------------------------------------------
  logic next_tx_bit;
  logic next_rx_pcm;

  always_comb begin
    next_tx_bit = tx_pcm;
    next_rx_pcm = rx_line;
    unique case (framer_loopback_select)
      TXC_LB_NONE: begin
        next_tx_bit = tx_pcm;
        next_rx_pcm = rx_line;
      end
      TXC_LB_LOCAL: begin
        next_tx_bit = 1'b1;
        next_rx_pcm = tx_pcm;
      end
      TXC_LB_REMOTE: begin
        next_tx_bit = rx_line;
        next_rx_pcm = rx_line;
      end
      TXC_LB_PAYLOAD: begin
        next_tx_bit = (bit_cnt == 8'h00) ? tx_pcm : rx_line;
        next_rx_pcm = rx_line;
      end
    endcase
    if (force_signal_loss_tx) begin
      next_tx_bit = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      tx_line_bit <= 1'b0;
      RX_PCM_O    <= 1'b0;
    end else if (tx_tick) begin
      tx_line_bit <= next_tx_bit;
      RX_PCM_O    <= next_rx_pcm;
    end
  end

  // ----------------------------------------------------------------
  // rail encoder
  // ----------------------------------------------------------------
  txc_rail_enc u_rail (
    .clk_i         (CLOCK_I),
    .rst_i         (RESET_I),
    .tick_i        (tx_tick),
    .bit_i         (next_tx_bit),
    .single_rail_i (single_rail),
    .pos_o         (TX_LINE_POS_O),
    .neg_o         (TX_LINE_NEG_O)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_LOOP_TIMING: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (~high_speed_mode && (tx_timing_source_select inside {TXC_SRC_LOOP, TXC_SRC_LOOP_B}))
    |-> (TX_SERIAL_CLOCK_OE_O && (tx_tick == (sync2[TXC_S_REC_CLK] & ~sync3[TXC_S_REC_CLK]))))
    else $error("loop timing source or pin direction wrong");

  AST_EXT_TIMING: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (tx_timing_source_select == TXC_SRC_EXT)
    |-> (!TX_SERIAL_CLOCK_OE_O && (tx_tick == (sync2[TXC_S_EXT_CLK] & ~sync3[TXC_S_EXT_CLK]))))
    else $error("external timing source or pin direction wrong");

  AST_PLL_TIMING: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (~high_speed_mode && (tx_timing_source_select == TXC_SRC_PLL))
    |-> (TX_SERIAL_CLOCK_OE_O && (tx_tick == (sync2[TXC_S_PLL_CLK] & ~sync3[TXC_S_PLL_CLK]))))
    else $error("pll timing source or pin direction wrong");

  AST_HIGH_SPEED_INPUTS: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    high_speed_mode
    |-> !(TX_SERIAL_CLOCK_OE_O || TX_FRAME_SYNC_OE_O || TX_MULTIFRAME_SYNC_OE_O))
    else $error("timing pin driven in high-speed mode");

  AST_SYNC_DIRECTION: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    !high_speed_mode
    |-> (TX_FRAME_SYNC_OE_O == sync_direction_invert)
        && (TX_MULTIFRAME_SYNC_OE_O == sync_direction_invert))
    else $error("sync pin direction does not follow invert bit");

  AST_FORCE_LOSS: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (tx_tick && force_signal_loss_tx) |=> !tx_line_bit)
    else $error("loss pattern not sent");

  AST_RAIL_GUARD: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (wr && hit_line_interface_control && !liu_single_rail) |=> !line_interface_control[TXC_RAIL_BIT])
    else $error("single rail set without global single rail");

  AST_NORMAL_PATH: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (tx_tick && !force_signal_loss_tx && framer_loopback_select == TXC_LB_NONE)
    |=> (tx_line_bit == $past(tx_pcm)) && (RX_PCM_O == $past(rx_line)))
    else $error("normal path broken");

  AST_LOCAL_RX: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (tx_tick && framer_loopback_select == TXC_LB_LOCAL) |=> (RX_PCM_O == $past(tx_pcm)))
    else $error("local loopback receive data wrong");

  AST_LOCAL_ONES: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (tx_tick && !force_signal_loss_tx && framer_loopback_select == TXC_LB_LOCAL)
    |=> tx_line_bit)
    else $error("all ones not sent in local loopback");

  AST_REMOTE_LOOP: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (tx_tick && !force_signal_loss_tx && framer_loopback_select == TXC_LB_REMOTE)
    |=> (tx_line_bit == $past(rx_line)))
    else $error("remote loopback data wrong");

  AST_PAYLOAD_LOOP: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (tx_tick && !force_signal_loss_tx && framer_loopback_select == TXC_LB_PAYLOAD
     && bit_cnt != 8'h00) |=> (tx_line_bit == $past(rx_line)))
    else $error("payload loopback data wrong");

  AST_RESERVED_QUIET: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (wr && hit_csr && wbyte[1:0] == tx_clock_select[1:0])
    |=> $stable(tx_timing_source_select) && $stable(TX_SERIAL_CLOCK_OE_O))
    else $error("reserved write changed clock selection");

endmodule // txc_tx_clock_loop

// File: hdl/txc_pkg.sv
package txc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          TXC_ADR_W            = 8;
  localparam logic [7:0]  TXC_ADR_CLOCK_SELECT = 8'h00;
  localparam logic [7:0]  TXC_ADR_LINE_IF_CTRL = 8'h04;
  localparam logic [7:0]  TXC_ADR_SYNC_MUX     = 8'h08;
  localparam logic [7:0]  TXC_ADR_BACKPLANE    = 8'h0c;
  localparam logic [7:0]  TXC_ADR_STATUS       = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          TXC_CSS_LSB          = 0;
  localparam int          TXC_FORCE_SIGNAL_LOSS_TX_BIT    = 7;
  localparam int          TXC_RAIL_BIT         = 6;
  localparam int          TXC_LB_LSB           = 4;
  localparam int          TXC_SYNC_DIRECTION_INVERT_BIT     = 4;
  localparam int          TXC_HIGH_SPEED_BIT   = 0;
  localparam int          TXC_LIU_SR_BIT       = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  TXC_RST_CLOCK_SELECT = 8'h11;
  localparam logic [7:0]  TXC_RST_LINE_IF_CTRL = 8'h00;
  localparam logic [7:0]  TXC_RST_SYNC_MUX     = 8'h00;
  localparam logic [7:0]  TXC_RST_BACKPLANE    = 8'h00;

  // ----------------------------------------------------------------
  // frame timing counts
  // ----------------------------------------------------------------
  localparam int          TXC_FRAME_BITS       = 193;
  localparam int          TXC_FRAMES_PER_MF    = 24;

  // ----------------------------------------------------------------
  // synchroniser lanes
  // ----------------------------------------------------------------
  localparam int          TXC_NSYNC            = 7;
  localparam int          TXC_S_REC_CLK        = 0;
  localparam int          TXC_S_PLL_CLK        = 1;
  localparam int          TXC_S_EXT_CLK        = 2;
  localparam int          TXC_S_TX_PCM         = 3;
  localparam int          TXC_S_RX_LINE        = 4;
  localparam int          TXC_S_FSYNC          = 5;
  localparam int          TXC_S_MFSYNC         = 6;

  typedef enum logic [1:0] {
    TXC_SRC_LOOP   = 2'b00,
    TXC_SRC_EXT    = 2'b01,
    TXC_SRC_PLL    = 2'b10,
    TXC_SRC_LOOP_B = 2'b11
  } txc_src_t;

  typedef enum logic [1:0] {
    TXC_LB_NONE    = 2'b00,
    TXC_LB_LOCAL   = 2'b01,
    TXC_LB_REMOTE  = 2'b10,
    TXC_LB_PAYLOAD = 2'b11
  } txc_lb_t;

endpackage

// File: hdl/txc_rail_enc.sv
`timescale 1ns/100ps

// ------------------------------------------------------------------
// rail encoder: single rail or alternating dual rail
// ------------------------------------------------------------------
module txc_rail_enc (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // bit stream
  input  wire logic tick_i,
  input  wire logic bit_i,
  input  wire logic single_rail_i,
  // rails
  output logic      pos_o,
  output logic      neg_o
);

  logic polarity;

  // ----------------------------------------------------------------
  // rail outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_o    <= 1'b0;
      neg_o    <= 1'b0;
      polarity <= 1'b0;
    end else if (tick_i) begin
      if (single_rail_i) begin
        pos_o <= bit_i;
        neg_o <= 1'b0;
      end else begin
        pos_o <= bit_i & ~polarity;
        neg_o <= bit_i & polarity;
        if (bit_i) begin
          polarity <= ~polarity;
        end
      end
    end
  end

endmodule // txc_rail_enc

// File: sim/txc_partner.sv
`timescale 1ns/100ps

// ------------------------------------------------------------------
// backplane partner: timing sources, sync pins and transmit pcm
// ------------------------------------------------------------------
module txc_partner (
  // clock
  input  wire logic clk_i,
  // backplane level requested by the bench
  input  wire logic pcm_i,
  // timing sources
  output logic      rec_clk_o,
  output logic      pll_clk_o,
  output logic      ext_clk_o,
  // sync pins and data
  output logic      sync_o,
  output logic      pcm_o
);
  logic [5:0] cnt = 6'h00;

  always_ff @(posedge clk_i) begin
    cnt <= cnt + 6'h01;
  end

  // recovered clock, period 16
  assign rec_clk_o = cnt[3];
  // pll clock, period 64
  assign pll_clk_o = cnt[5];
  // external serial clock, period 32, driven while the pin is an input
  assign ext_clk_o = cnt[4];
  // frame and multiframe sync held inactive when the pins are inputs
  assign sync_o    = 1'b0;
  assign pcm_o     = pcm_i;
endmodule // txc_partner

// File: sim/tx_clock_and_loopback_control_test.sv
`timescale 1ns/100ps

// ------------------------------------------------------------------
// bench
// ------------------------------------------------------------------
module tx_clock_and_loopback_control_test;
  import txc_pkg::*;
  localparam int TB_FRAME_BITS    = 8;
  localparam int TB_FRAMES_PER_MF = 3;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        cyc  = 1'b0;
  logic        stb  = 1'b0;
  logic        we   = 1'b0;
  logic [7:0]  adr  = 8'h00;
  logic [3:0]  sel  = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic        pcm  = 1'b0;
  logic        rxl  = 1'b0;
  logic [31:0] q;
  logic [13:0] tab [14];
  int          n_fail  = 0;
  int          n_tests = 0;
  int          k;
  int          n;
  wire logic [31:0] rdat;
  wire logic   ack, rec, pll, ext, psync, ppcm, sc_o, sc_oe;
  wire logic   fs_o, fs_oe, mf_o, mf_oe, rxpcm, pos, neg;
  wire logic   sc_pin = sc_oe ? sc_o : ext;
  wire logic   fs_pin = fs_oe ? fs_o : psync;
  wire logic   mf_pin = mf_oe ? mf_o : psync;

  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task end_sim;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'h1;
    wdat <= {24'h0, d};
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    q = rdat;
    if (i == 16) begin
      n_fail++;
      end_sim();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask

  task ones(input logic [1:0] s, output int c);
    c = 0;
    repeat (64) @(posedge clk);
    repeat (64) begin
      @(posedge clk);
      c += ((s == 2'd0 ? rxpcm : s == 2'd1 ? pos : neg) === 1'b1);
    end
  endtask

  task edges(output int c);
    logic last;
    c = 0;
    last = sc_o;
    repeat (320) begin
      @(posedge clk);
      if (sc_o === 1'b1 && last === 1'b0) c++;
      last = sc_o;
    end
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    tab[0]  = {8'h40, 1'b0, 1'b1, 2'd0, 2'd1};
    tab[1]  = {8'h40, 1'b1, 1'b0, 2'd0, 2'd0};
    tab[2]  = {8'h40, 1'b1, 1'b0, 2'd1, 2'd1};
    tab[3]  = {8'h50, 1'b1, 1'b0, 2'd0, 2'd1};
    tab[4]  = {8'h50, 1'b0, 1'b1, 2'd0, 2'd0};
    tab[5]  = {8'h5c, 1'b0, 1'b0, 2'd1, 2'd1};
    tab[6]  = {8'h50, 1'b0, 1'b0, 2'd2, 2'd0};
    tab[7]  = {8'hc0, 1'b1, 1'b1, 2'd1, 2'd0};
    tab[8]  = {8'hd0, 1'b1, 1'b1, 2'd1, 2'd0};
    tab[9]  = {8'h60, 1'b0, 1'b1, 2'd1, 2'd1};
    tab[10] = {8'h60, 1'b1, 1'b0, 2'd1, 2'd0};
    tab[11] = {8'h70, 1'b0, 1'b1, 2'd1, 2'd1};
    tab[12] = {8'h70, 1'b1, 1'b0, 2'd1, 2'd0};
    tab[13] = {8'h10, 1'b0, 1'b0, 2'd2, 2'd2};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, TXC_ADR_CLOCK_SELECT, 8'h00);
    chk(q, {24'h0, TXC_RST_CLOCK_SELECT});
    chk(sc_oe, 1'b0);
    wb(1'b0, 8'h20, 8'h00);
    chk(q, 32'h0);
    wb(1'b1, TXC_ADR_LINE_IF_CTRL, 8'h40);
    wb(1'b0, TXC_ADR_LINE_IF_CTRL, 8'h00);
    chk(q, 32'h0);
    for (k = 0; k < 4; k++) begin
      wb(1'b1, TXC_ADR_CLOCK_SELECT, 8'h0c | k[7:0]);
      wb(1'b0, TXC_ADR_CLOCK_SELECT, 8'h00);
      chk(q, {24'h0, 8'h0c | k[7:0]});
      chk(sc_oe, k != 1);
      wb(1'b0, TXC_ADR_STATUS, 8'h00);
      chk(q[2:0], {k != 1, k[1:0]});
      if (k != 1) begin
        edges(n);
        chk(n >= (k == 2 ? 4 : 19) && n <= (k == 2 ? 6 : 21), 1'b1);
      end
    end
    wb(1'b1, TXC_ADR_CLOCK_SELECT, 8'hf3);
    wb(1'b0, TXC_ADR_CLOCK_SELECT, 8'h00);
    chk(q, 32'h0000_00f3);
    chk(sc_oe, 1'b1);
    wb(1'b1, TXC_ADR_SYNC_MUX, 8'h10);
    chk({fs_oe, mf_oe}, 2'b11);
    wb(1'b0, TXC_ADR_STATUS, 8'h00);
    chk(q[3], 1'b1);
    wb(1'b1, TXC_ADR_BACKPLANE, 8'h01);
    chk({sc_oe, fs_oe, mf_oe}, 3'b000);
    wb(1'b1, TXC_ADR_BACKPLANE, 8'h02);
    wb(1'b1, TXC_ADR_SYNC_MUX, 8'h00);
    chk({fs_oe, mf_oe}, 2'b00);
    for (k = 0; k < 14; k++) begin
      pcm <= tab[k][5];
      rxl <= tab[k][4];
      wb(1'b1, TXC_ADR_LINE_IF_CTRL, tab[k][13:6]);
      wb(1'b0, TXC_ADR_LINE_IF_CTRL, 8'h00);
      chk(q, {24'h0, tab[k][13:6]});
      ones(tab[k][3:2], n);
      chk(tab[k][1:0] == 2'd0 ? n <= 16 : tab[k][1:0] == 2'd1 ? n >= 48 :
          (n >= 16 && n <= 48), 1'b1);
    end
    // frame and multiframe sync pulses driven out in base rate
    wb(1'b1, TXC_ADR_SYNC_MUX, 8'h10);
    n = 0;
    k = 0;
    repeat (768) begin
      @(posedge clk);
      n += (fs_o === 1'b1);
      k += (mf_o === 1'b1);
    end
    chk(n, 768 / TB_FRAME_BITS);
    chk(k, 768 / (TB_FRAME_BITS * TB_FRAMES_PER_MF));
    end_sim();
  end

  txc_partner u_txc_partner (
    .clk_i     (clk),
    .pcm_i     (pcm),
    .rec_clk_o (rec),
    .pll_clk_o (pll),
    .ext_clk_o (ext),
    .sync_o    (psync),
    .pcm_o     (ppcm)
  );

  txc_tx_clock_loop #(
    .FRAME_BITS    (TB_FRAME_BITS),
    .FRAMES_PER_MF (TB_FRAMES_PER_MF)
  ) u_txc_tx_clock_loop (
    .CLOCK_I                 (clk),
    .RESET_I                 (rst),
    .WB_CYC_I                (cyc),
    .WB_STB_I                (stb),
    .WB_WE_I                 (we),
    .WB_ADR_I                (adr),
    .WB_SEL_I                (sel),
    .WB_DAT_I                (wdat),
    .WB_DAT_O                (rdat),
    .WB_ACK_O                (ack),
    .RECOVERED_CLK_I         (rec),
    .PLL_CLK_I               (pll),
    .TX_SERIAL_CLOCK_I       (sc_pin),
    .TX_SERIAL_CLOCK_O       (sc_o),
    .TX_SERIAL_CLOCK_OE_O    (sc_oe),
    .TX_FRAME_SYNC_I         (fs_pin),
    .TX_FRAME_SYNC_O         (fs_o),
    .TX_FRAME_SYNC_OE_O      (fs_oe),
    .TX_MULTIFRAME_SYNC_I    (mf_pin),
    .TX_MULTIFRAME_SYNC_O    (mf_o),
    .TX_MULTIFRAME_SYNC_OE_O (mf_oe),
    .TX_PCM_I                (ppcm),
    .RX_LINE_I               (rxl),
    .RX_PCM_O                (rxpcm),
    .TX_LINE_POS_O           (pos),
    .TX_LINE_NEG_O           (neg)
  );
endmodule // tx_clock_and_loopback_control_test
